// ===== dgeis_top.sv
// dma global enable, bus error status and channel interrupt status
// What this block does
// - nothing is configured or transferred until the global enable is set.
// - once enable is cleared, stay idle and ignore requests until set again.
// - error status reads non-zero while a bus error pends, else zero.
// - error clear removes pending error and drops the error interrupt.
// - a 32-bit channel interrupt status word is readable at any time.
// - status bit 1 means channel requests interrupt; many may be set.
// - clear mask write clears masked channels, others keep their status.
// - at transfer end write the stopped encoding into the mode field.
`timescale 1ns/10ps
`default_nettype none

module dgeis_top #(
  parameter int unsigned N = dgeis_pkg::NUM_CHANNELS
) (
  // clock and reset
  input  wire logic                          SYS_CLK,
  input  wire logic                          RESET,
  // global enable control
  input  wire logic                          ENABLE_SET,
  input  wire logic                          ENABLE_CLEAR,
  output logic                               CTRL_ENABLED,
  // channel configuration attempts
  input  wire logic                          CFG_WRITE_REQ,
  output logic                               CFG_WRITE_ACCEPT,
  // channel requests
  input  wire logic [N-1:0]                  CHAN_REQ,
  output logic [N-1:0]                       CHAN_REQ_GATED,
  // bus error status
  input  wire logic                          BUS_ERROR,
  input  wire logic                          ERROR_CLEAR,
  output logic [dgeis_pkg::ERR_W-1:0]        ERROR_STATUS,
  output logic                               ERROR_IRQ,
  // channel completion and interrupt status
  input  wire logic [N-1:0]                  CHAN_DONE,
  input  wire logic                          CLEAR_MASK_WR,
  input  wire logic [N-1:0]                  CHANNEL_CLEAR_MASK,
  output logic [N-1:0]                       INT_STATUS,
  // transfer mode write-back
  output logic [N-1:0]                       MODE_STOP_STROBE,
  output logic [dgeis_pkg::MODE_W-1:0]       TRANSFER_MODE_STOPPED
);

  dgeis_pkg::dgeis_state_t state_q;
  logic                    en_q;
  logic                    accept_q;
  logic [N-1:0]            req_q;
  logic [dgeis_pkg::ERR_W-1:0] err_q;
  logic                    err_irq_q;
  logic [N-1:0]            stop_q;
  logic [dgeis_pkg::MODE_W-1:0] mode_q;
  logic [N-1:0]            done_en;

  dgeis_irq_if #(.N(N)) irq_bus ();

  // ==========================================================
  // global enable state, clear wins over a simultaneous set
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_q <= dgeis_pkg::DGEIS_OFF;
    end else begin
      case (state_q)
        dgeis_pkg::DGEIS_OFF: begin
          if (ENABLE_SET && !ENABLE_CLEAR) begin
            state_q <= dgeis_pkg::DGEIS_ON;
          end
        end
        dgeis_pkg::DGEIS_ON: begin
          if (ENABLE_CLEAR) begin
            state_q <= dgeis_pkg::DGEIS_OFF;
          end
        end
        default: begin
          state_q <= dgeis_pkg::DGEIS_OFF;
        end
      endcase
    end
  end

  // enable flag as a plain register for the output and gating
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      en_q <= 1'b0;
    end else begin
      en_q <= (state_q == dgeis_pkg::DGEIS_OFF) ?
              (ENABLE_SET && !ENABLE_CLEAR) : !ENABLE_CLEAR;
    end
  end

  // ==========================================================
  // configuration and request gating by the enable
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      accept_q <= 1'b0;
      req_q    <= '0;
    end else begin
      accept_q <= CFG_WRITE_REQ && en_q;
      req_q    <= en_q ? CHAN_REQ : '0;
    end
  end

  // ==========================================================
  // bus error pending, a new error wins over a clear
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      err_q     <= dgeis_pkg::ERR_RST;
      err_irq_q <= 1'b0;
    end else if (BUS_ERROR) begin
      err_q     <= dgeis_pkg::ERR_PENDING_VALUE;
      err_irq_q <= 1'b1;
    end else if (ERROR_CLEAR) begin
      err_q     <= dgeis_pkg::ERR_RST;
      err_irq_q <= 1'b0;
    end
  end

  // ==========================================================
  // completion events only count while enabled
  assign done_en          = en_q ? CHAN_DONE : '0;
  assign irq_bus.done_evt = done_en;
  assign irq_bus.clr_we   = CLEAR_MASK_WR;
  assign irq_bus.clr_mask = CHANNEL_CLEAR_MASK;

  // sticky per-channel status
  dgeis_chan_irq #(.N(N)) u_chan_irq (
    .clk (SYS_CLK),
    .rst (RESET),
    .bus (irq_bus.irq)
  );

  // ==========================================================
  // mode write-back strobes at transfer end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stop_q <= '0;
      mode_q <= dgeis_pkg::TRANSFER_MODE_STOPPED;
    end else begin
      stop_q <= done_en;
      mode_q <= dgeis_pkg::TRANSFER_MODE_STOPPED;
    end
  end

  // outputs
  assign CTRL_ENABLED          = en_q;
  assign CFG_WRITE_ACCEPT      = accept_q;
  assign CHAN_REQ_GATED        = req_q;
  assign ERROR_STATUS          = err_q;
  assign ERROR_IRQ             = err_irq_q;
  assign INT_STATUS            = irq_bus.status;
  assign MODE_STOP_STROBE      = stop_q;
  assign TRANSFER_MODE_STOPPED = mode_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  AST_CFG_BLOCKED: assert property (
    CFG_WRITE_REQ && !en_q |=> !CFG_WRITE_ACCEPT)
    else $error("config accepted while disabled");

  AST_CFG_TAKEN: assert property (
    CFG_WRITE_REQ && en_q |=> CFG_WRITE_ACCEPT)
    else $error("config refused while enabled");

  AST_IDLE_OFF: assert property (
    ENABLE_CLEAR |=> !CTRL_ENABLED ##1 (CHAN_REQ_GATED == '0))
    else $error("requests passed after disable");

  AST_REQ_PASS: assert property (
    en_q |=> CHAN_REQ_GATED == $past(CHAN_REQ))
    else $error("request not passed while enabled");

  AST_ERR_SET: assert property (
    BUS_ERROR |=> (ERROR_STATUS != '0) && ERROR_IRQ)
    else $error("bus error not pending");

  AST_ERR_CLR: assert property (
    ERROR_CLEAR && !BUS_ERROR |=> (ERROR_STATUS == '0) && !ERROR_IRQ)
    else $error("error clear failed");

  AST_ERR_HOLD: assert property (
    !BUS_ERROR && !ERROR_CLEAR |=> $stable(ERROR_STATUS))
    else $error("error status changed without cause");

  AST_INT_SET: assert property (
    done_en != '0 |=> (INT_STATUS & $past(done_en)) == $past(done_en))
    else $error("completion did not set status");

  AST_INT_CLR: assert property (
    CLEAR_MASK_WR |=> (INT_STATUS & $past(CHANNEL_CLEAR_MASK)
                       & ~$past(done_en)) == '0)
    else $error("masked channel not cleared");

  AST_INT_KEEP: assert property (
    CLEAR_MASK_WR |=> (INT_STATUS & ~$past(CHANNEL_CLEAR_MASK)) ==
      (($past(INT_STATUS) | $past(done_en)) & ~$past(CHANNEL_CLEAR_MASK)))
    else $error("unmasked channel status changed");

  AST_STOP_WR: assert property (
    done_en != '0 |=> MODE_STOP_STROBE == $past(done_en) &&
      TRANSFER_MODE_STOPPED == dgeis_pkg::TRANSFER_MODE_STOPPED)
    else $error("stop mode not written at completion");

  // set and clear together while off must leave the controller off
  AST_SET_CLR_REFUSED: assert property (
    !en_q && ENABLE_SET && ENABLE_CLEAR |=> !CTRL_ENABLED)
    else $error("enable taken despite simultaneous clear");

  // a disabled controller shows no accept and no stop write-back
  AST_STOP_IDLE: assert property (
    !en_q |=> (MODE_STOP_STROBE == '0) && !CFG_WRITE_ACCEPT)
    else $error("activity while disabled");

  COV_ENABLE_CFG: cover property (
    ENABLE_SET ##1 CTRL_ENABLED ##1 CFG_WRITE_REQ ##1 CFG_WRITE_ACCEPT);

  COV_ERR_CYCLE: cover property (
    BUS_ERROR ##1 ERROR_IRQ ##[1:4] ERROR_CLEAR ##1 !ERROR_IRQ);

  COV_MULTI_INT: cover property (
    $countones(INT_STATUS) > 1 ##1 CLEAR_MASK_WR);

  COV_DISABLE_IDLE: cover property (
    CTRL_ENABLED && ENABLE_CLEAR ##1 !CTRL_ENABLED ##1 CHAN_DONE != '0);

endmodule

`default_nettype wire

// ===== dgeis_pkg.sv
// constants shared by the dma global enable and interrupt status block
`default_nettype none

package dgeis_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned NUM_CHANNELS = 32;
  localparam int unsigned MODE_W       = 3;
  localparam int unsigned ERR_W        = 32;

  // ==========================================================
  // encodings and reset values
  localparam logic [MODE_W-1:0] TRANSFER_MODE_STOPPED = 3'h0;
  localparam logic [ERR_W-1:0]  ERR_PENDING_VALUE     = 32'h00000001;
  localparam logic [ERR_W-1:0]  ERR_RST               = 32'h00000000;
  localparam logic [NUM_CHANNELS-1:0] INT_RST         = 32'h00000000;

  // ==========================================================
  // controller-wide state
  typedef enum logic {
    DGEIS_OFF,
    DGEIS_ON
  } dgeis_state_t;

endpackage

`default_nettype wire

// ===== dgeis_irq_if.sv
// carrier between the top and the channel interrupt status module
`timescale 1ns/10ps
`default_nettype none

interface dgeis_irq_if #(
  parameter int unsigned N = dgeis_pkg::NUM_CHANNELS
);
  logic [N-1:0] done_evt;  // gated completion events, one cycle
  logic         clr_we;    // clear mask write strobe
  logic [N-1:0] clr_mask;  // channels to clear
  logic [N-1:0] status;    // sticky interrupt status

  modport ctrl (output done_evt, output clr_we, output clr_mask,
                input status);
  modport irq  (input done_evt, input clr_we, input clr_mask,
                output status);
endinterface

`default_nettype wire

// ===== dgeis_chan_irq.sv
// per-channel sticky interrupt status with selective clear
`timescale 1ns/10ps
`default_nettype none

module dgeis_chan_irq #(
  parameter int unsigned N = dgeis_pkg::NUM_CHANNELS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // status carrier
  dgeis_irq_if.irq  bus
);

  logic [N-1:0] status_q;
  logic [N-1:0] status_d;

  // ==========================================================
  // next status: clear masked bits, completion sets win over clear
  always_comb begin
    status_d = status_q;
    if (bus.clr_we) begin
      status_d = status_q & ~bus.clr_mask;
    end
    status_d = status_d | bus.done_evt;
  end

  // status register
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= dgeis_pkg::INT_RST[N-1:0];
    end else begin
      status_q <= status_d;
    end
  end

  assign bus.status = status_q;

endmodule

`default_nettype wire

// ===== dgeis_tb.sv
// self-checking bench for the dma global enable and interrupt status block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ==========================================================
  // stimulus and observed signals
  logic        clk, rst, en_set, en_clr, cfg_req, bus_err, err_clr, mask_wr;
  logic [31:0] chan_req, done, mask;
  logic        enabled, cfg_acc, err_irq;
  logic [31:0] req_g, err_st, int_st, stop_stb;
  logic [2:0]  mode_stop;
  int          miscompares, n_compared, cycles;

  dgeis_top #(.N(32)) u_dut (
    .SYS_CLK(clk), .RESET(rst), .ENABLE_SET(en_set), .ENABLE_CLEAR(en_clr),
    .CTRL_ENABLED(enabled), .CFG_WRITE_REQ(cfg_req),
    .CFG_WRITE_ACCEPT(cfg_acc), .CHAN_REQ(chan_req),
    .CHAN_REQ_GATED(req_g), .BUS_ERROR(bus_err), .ERROR_CLEAR(err_clr),
    .ERROR_STATUS(err_st), .ERROR_IRQ(err_irq), .CHAN_DONE(done),
    .CLEAR_MASK_WR(mask_wr), .CHANNEL_CLEAR_MASK(mask),
    .INT_STATUS(int_st), .MODE_STOP_STROBE(stop_stb),
    .TRANSFER_MODE_STOPPED(mode_stop));

  // ==========================================================
  // clock, time limit and reporting
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // a hang is cut short well past the expected length of the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one cycle of stimulus: inputs seen at the next edge, checked after it
  task automatic pulse(input logic s, c, q, e, ec, w, input logic [31:0] d,
                       input logic [31:0] m);
    @(posedge clk);
    en_set <= s; en_clr <= c; cfg_req <= q; bus_err <= e;
    err_clr <= ec; mask_wr <= w; done <= d; mask <= m;
    @(posedge clk);
    en_set <= 1'b0; en_clr <= 1'b0; cfg_req <= 1'b0; bus_err <= 1'b0;
    err_clr <= 1'b0; mask_wr <= 1'b0; done <= 32'h0; mask <= 32'h0;
    @(negedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_before_enable();
    check(32'(mode_stop), 32'(dgeis_pkg::TRANSFER_MODE_STOPPED));
    check(err_st, dgeis_pkg::ERR_RST);
    check(32'(err_irq), 32'h0);
    @(posedge clk);
    chan_req <= 32'hFFFFFFFF;
    pulse(0, 0, 1, 0, 0, 0, 32'h00000001, 32'h0);
    check(32'(enabled), 32'h0);
    check(32'(cfg_acc), 32'h0);
    check(req_g, 32'h0);
    check(int_st, 32'h0);
    check(stop_stb, 32'h0);
    $display("test before_enable done");
  endtask

  task automatic t_enable();
    @(posedge clk);
    chan_req <= 32'hA5A5A5A5;
    pulse(1, 0, 0, 0, 0, 0, 32'h0, 32'h0);
    check(32'(enabled), 32'h1);
    pulse(0, 0, 1, 0, 0, 0, 32'h0, 32'h0);
    check(32'(cfg_acc), 32'h1);
    check(req_g, 32'hA5A5A5A5);
    @(negedge clk);
    check(32'(cfg_acc), 32'h0);
    $display("test enable done");
  endtask

  task automatic t_irq();
    pulse(0, 0, 0, 0, 0, 0, 32'h80000001, 32'h0);
    check(int_st, 32'h80000001);
    check(stop_stb, 32'h80000001);
    check(32'(mode_stop), 32'(dgeis_pkg::TRANSFER_MODE_STOPPED));
    @(negedge clk);
    check(stop_stb, 32'h0);
    check(int_st, 32'h80000001);
    pulse(0, 0, 0, 0, 0, 0, 32'h00000010, 32'h0);
    check(int_st, 32'h80000011);
    // clear of bits 31 and 4 while bit 4 completes again: bit 4 stays
    pulse(0, 0, 0, 0, 0, 1, 32'h00000010, 32'h80000010);
    check(int_st, 32'h00000011);
    pulse(0, 0, 0, 0, 0, 1, 32'h0, 32'h00000010);
    check(int_st, 32'h00000001);
    pulse(0, 0, 0, 0, 0, 1, 32'h0, 32'hFFFFFFFF);
    check(int_st, 32'h0);
    $display("test irq done");
  endtask

  task automatic t_disable();
    @(posedge clk);
    chan_req <= 32'h0000FFFF;
    pulse(1, 1, 0, 0, 0, 0, 32'h0, 32'h0);
    check(32'(enabled), 32'h0);
    pulse(0, 0, 1, 0, 0, 0, 32'h00000100, 32'h0);
    check(32'(cfg_acc), 32'h0);
    check(req_g, 32'h0);
    check(int_st, 32'h0);
    check(stop_stb, 32'h0);
    pulse(1, 1, 0, 0, 0, 0, 32'h0, 32'h0);
    check(32'(enabled), 32'h0);
    pulse(1, 0, 0, 0, 0, 0, 32'h0, 32'h0);
    check(32'(enabled), 32'h1);
    $display("test disable done");
  endtask

  task automatic t_error();
    pulse(0, 1, 0, 1, 0, 0, 32'h0, 32'h0);
    check(err_st, dgeis_pkg::ERR_PENDING_VALUE);
    check(32'(err_irq), 32'h1);
    repeat (3) @(negedge clk);
    check(err_st, dgeis_pkg::ERR_PENDING_VALUE);
    pulse(0, 0, 0, 1, 1, 0, 32'h0, 32'h0);
    check(32'(err_irq), 32'h1);
    pulse(0, 0, 0, 0, 1, 0, 32'h0, 32'h0);
    check(err_st, 32'h0);
    check(32'(err_irq), 32'h0);
    $display("test error done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    miscompares = 0; n_compared = 0; cycles = 0;
    rst = 1'b1; en_set = 1'b0; en_clr = 1'b0; cfg_req = 1'b0;
    bus_err = 1'b0; err_clr = 1'b0; mask_wr = 1'b0;
    chan_req = 32'h0; done = 32'h0; mask = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_before_enable();
    t_enable();
    t_irq();
    t_disable();
    t_error();
    summarize();
  end
endmodule

`default_nettype wire
